// ==== dv/ctrl_model.sv ====
/* controller model: input clock pair and the late parity bit.
   assumes the bench presents each word at a falling edge. */
`timescale 1ns/1ps
module ctrl_model (
   // clock
   input wire logic core_clk,
   // word and commands from the bench
   input wire parity_pkg::ca_word_t word,
   input wire logic flip,
   input wire logic stop,
   input wire logic err_oe,
   // pins toward the device
   output logic parity_bit_in,
   output logic ck_in,
   output logic ck_n_in
);
   logic par_q = 1'b0;
   logic halt = 1'b0;
   initial
   begin
      parity_bit_in = 1'b0;
      ck_in = 1'b0;
      ck_n_in = 1'b1;
   end
   // even parity taken where the device takes the word; flip forces an error
   always @(posedge core_clk) par_q <= ^word ^ flip;
   // parity lands one cycle late; parked only both low, never during an error
   always @(negedge core_clk)
   begin
      parity_bit_in <= par_q;
      if (!err_oe) halt = stop;
      ck_in <= halt ? 1'b0 : ~ck_in;
      ck_n_in <= halt ? 1'b0 : ck_in;
   end
endmodule : ctrl_model

// ==== dv/parity_checker.sv ====
/* assertions on error pulse timing and clock output control.
   assumes bind to cmd_parity_check_clock_out and inputs that move at falling edges. */
`timescale 1ns/1ps
module parity_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // watched inputs
   input wire logic [parity_pkg::CS_W-1:0] chip_select_in_n,
   input wire logic [parity_pkg::ROW_COL_W-1:0] row_col_addr_in,
   input wire logic [parity_pkg::BANK_W-1:0] bank_addr_in,
   input wire logic row_strobe_in_n,
   input wire logic col_strobe_in_n,
   input wire logic write_strobe_in_n,
   input wire logic parity_bit_in,
   input wire logic ck_in,
   input wire logic ck_n_in,
   input wire logic analog_supply,
   input wire logic [parity_pkg::MODE_W-1:0] drv_mode_word,
   // watched outputs
   input wire logic parity_error_oe,
   input wire logic clock_out_oe,
   input wire logic feedback_clock_out,
   input wire logic feedback_clock_out_n,
   input wire logic feedback_clock_oe,
   input wire logic pll_on,
   input wire logic pll_bypass
);
   logic par_q;
   logic sel_q;
   logic [2:0] up_q;
   logic [5:0] low_cnt;
   wire bad = sel_q & (par_q ^ parity_bit_in);
   // word parity kept one edge to meet the late parity bit
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n)
      begin
         par_q <= 1'b0;
         sel_q <= 1'b0;
         up_q <= 3'h0;
         low_cnt <= 6'h0;
      end
      else
      begin
         par_q <= ^{row_col_addr_in, bank_addr_in, row_strobe_in_n, col_strobe_in_n,
            write_strobe_in_n};
         sel_q <= ~&chip_select_in_n;
         up_q <= {up_q[1:0], 1'b1};
         low_cnt <= (ck_in | ck_n_in) ? 6'h0 : low_cnt + {5'h0, low_cnt != 6'h3f};
      end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   err_rise_a: assert property (bad |-> ##3 parity_error_oe)
      else $error("error pin missed a failing word");
   no_false_a: assert property ($rose(parity_error_oe) |-> $past(bad, 3))
      else $error("error pin without a failing word");
   hold_two_a: assert property ($rose(parity_error_oe) |=> parity_error_oe
      ##1 (!parity_error_oe || $past(bad, 3))) else $error("error pulse width wrong");
   clk_off_a: assert property (drv_mode_word[0] |=> !clock_out_oe)
      else $error("clock pairs driven while disabled");
   fb_follow_a: assert property (up_q[2] && feedback_clock_oe |->
      feedback_clock_out == $past(ck_in, 3) && feedback_clock_out_n != feedback_clock_out)
      else $error("feedback clock not following input");
   rel_idle_a: assert property ($rose(rst_n) |-> !parity_error_oe && !clock_out_oe
      && !feedback_clock_oe && !pll_on) else $error("outputs not idle after reset");
   bypass_a: assert property (up_q[2] |-> pll_bypass == !$past(analog_supply, 3))
      else $error("bypass not following supply sense");
   stop_low_a: assert property (low_cnt >= 6'h37 |-> !clock_out_oe
      && !feedback_clock_oe && !parity_error_oe && !pll_on) else $error("stopped clock not idle");
   cover property ($rose(parity_error_oe));
   cover property (low_cnt == 6'h37);
   cover property (pll_bypass && up_q[2]);
endmodule : parity_checker

bind cmd_parity_check_clock_out parity_checker i_chk (.core_clk, .rst_n, .chip_select_in_n,
   .row_col_addr_in, .bank_addr_in, .row_strobe_in_n, .col_strobe_in_n, .write_strobe_in_n,
   .parity_bit_in, .ck_in, .ck_n_in, .analog_supply, .drv_mode_word, .parity_error_oe,
   .clock_out_oe, .feedback_clock_out, .feedback_clock_out_n, .feedback_clock_oe, .pll_on,
   .pll_bypass);

// ==== dv/tb_top.sv ====
/* self-checking bench for the parity checker and clock output control.
   assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic [3:0] cs;
      logic [3:0] ctl;
      logic [21:0] w;
      logic flip;
      logic err;
   } row_t;
   logic core_clk, rst_n, stop, flip, ck_in, ck_n_in, par, asup, err_n, err_oe;
   logic coe, fb, fbn, fboe, pon, pby;
   logic [3:0] cs_n, ctl, mode, cop, copn;
   parity_pkg::ca_word_t word;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   // ctl noise must not reach the parity sum; last row is deselected
   // an error comes only from a bad parity bit on a selected word
   row_t rows [5] = '{'{4'he, 4'h0, 22'h0, 1'b0, 1'b0}, '{4'hd, 4'hf, 22'h1, 1'b0, 1'b0},
      '{4'hb, 4'h0, 22'h3ffffe, 1'b1, 1'b1}, '{4'h7, 4'ha, 22'h300000, 1'b1, 1'b1},
      '{4'hf, 4'h0, 22'h1, 1'b1, 1'b0}};
   cmd_parity_check_clock_out i_dut (.core_clk(core_clk), .rst_n(rst_n),
      .chip_select_in_n(cs_n), .row_col_addr_in(word.row_col_addr),
      .bank_addr_in(word.bank_addr), .row_strobe_in_n(word.row_strobe_n),
      .col_strobe_in_n(word.col_strobe_n), .write_strobe_in_n(word.write_strobe_n),
      .clk_enable_in(ctl[3:2]), .termination_ctrl_in(ctl[1:0]), .parity_bit_in(par),
      .ck_in(ck_in), .ck_n_in(ck_n_in), .analog_supply(asup), .drv_mode_word(mode),
      .parity_error_out_n(err_n), .parity_error_oe(err_oe), .clock_out_pair(cop),
      .clock_out_pair_n(copn), .clock_out_oe(coe), .feedback_clock_out(fb),
      .feedback_clock_out_n(fbn), .feedback_clock_oe(fboe), .pll_on(pon), .pll_bypass(pby));
   ctrl_model i_ctrl (.core_clk(core_clk), .word(word), .flip(flip), .stop(stop),
      .err_oe(err_oe), .parity_bit_in(par), .ck_in(ck_in), .ck_n_in(ck_n_in));
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task chk(input string nm, input logic e, input logic a);
      n_tests++;
      if (a !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, a);
      end
   endtask : chk
   // one word, optionally repeated next cycle; the repeat falls in the hold
   task send(input row_t r, input logic two);
      cs_n = r.cs;
      ctl = r.ctl;
      word = r.w;
      flip = r.flip;
      @(negedge core_clk);
      if (!two) cs_n = 4'hf;
      @(negedge core_clk);
      cs_n = 4'hf;
      repeat (2) @(negedge core_clk);
      chk("error first cycle", r.err, err_oe);
      @(negedge core_clk);
      chk("error second cycle", r.err, err_oe);
      @(negedge core_clk);
      chk("error released", 1'b0, err_oe);
   endtask : send
   // hang guard, well above the roughly 145 cycles needed
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         num_errors++;
         report_and_stop();
      end
   end
   initial
   begin
      {rst_n, stop, flip, ctl, mode} = 11'h0;
      asup = 1'b1;
      cs_n = 4'hf;
      word = '0;
      repeat (12) @(negedge core_clk);
      chk("idle in reset", 1'b0, err_oe | coe | fboe | pon);
      chk("error pin value", 1'b0, err_n);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      foreach (rows[i])
      begin
         send(rows[i], 1'b0);
         $display("row %0d done", i);
      end
      send(rows[2], 1'b1);
      $display("back to back done");
      mode = 4'h1;
      repeat (3) @(negedge core_clk);
      chk("pairs floated", 1'b0, coe);
      chk("feedback runs", 1'b1, fboe);
      mode = 4'h0;
      asup = 1'b0;
      repeat (5) @(negedge core_clk);
      chk("pairs driven", 1'b1, coe);
      chk("pll bypassed", 1'b1, pby);
      chk("pairs follow feedback", 1'b1, cop == {4{fb}} && copn == ~cop);
      asup = 1'b1;
      stop = 1'b1;
      repeat (60) @(negedge core_clk);
      chk("stopped idle", 1'b0, coe | fboe | pon | err_oe);
      stop = 1'b0;
      repeat (10) @(negedge core_clk);
      chk("restart", 1'b1, coe & fboe & pon & ~pby);
      $display("clock control done");
      cs_n = 4'hd;
      word = 22'h1;
      flip = 1'b1;
      @(negedge core_clk);
      cs_n = 4'hf;
      repeat (3) @(negedge core_clk);
      chk("error before reset", 1'b1, err_oe);
      rst_n = 1'b0;
      #1 chk("reset clears error", 1'b0, err_oe);
      @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      send(rows[2], 1'b0);
      $display("mid reset done");
      report_and_stop();
   end
endmodule : tb_top

// ==== rtl/cmd_parity_check_clock_out.sv ====
/*
 * command/address even-parity checker with open-drain error output, plus the
 * enable, float and bypass control of the clock and feedback clock outputs.
 * assumes command, address, chip select and parity come from logic on
 * core_clk; the input clock levels and analog supply sense are pin levels.
 */
`timescale 1ns/1ps
module cmd_parity_check_clock_out (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // command and address from the controller
   input wire logic [parity_pkg::CS_W-1:0] chip_select_in_n,
   input wire logic [parity_pkg::ROW_COL_W-1:0] row_col_addr_in,
   input wire logic [parity_pkg::BANK_W-1:0] bank_addr_in,
   input wire logic row_strobe_in_n,
   input wire logic col_strobe_in_n,
   input wire logic write_strobe_in_n,
   input wire logic [1:0] clk_enable_in,
   input wire logic [1:0] termination_ctrl_in,
   input wire logic parity_bit_in,
   // input clock pair levels and supply sense
   input wire logic ck_in,
   input wire logic ck_n_in,
   input wire logic analog_supply,
   // clock driver mode control word
   input wire logic [parity_pkg::MODE_W-1:0] drv_mode_word,
   // open-drain error pin, drives low while oe is high
   output logic parity_error_out_n,
   output logic parity_error_oe,
   // clock output pairs
   output logic [parity_pkg::CLK_PAIRS-1:0] clock_out_pair,
   output logic [parity_pkg::CLK_PAIRS-1:0] clock_out_pair_n,
   output logic clock_out_oe,
   // feedback clock pair
   output logic feedback_clock_out,
   output logic feedback_clock_out_n,
   output logic feedback_clock_oe,
   // pll status
   output logic pll_on,
   output logic pll_bypass
);

   parity_pkg::chk_state_t st_r;
   parity_pkg::chk_state_t st_nxt;
   parity_pkg::ca_word_t word_in;
   logic [2:0] pin_sync;
   logic ck_s;
   logic ck_n_s;
   logic analog_s;
   logic clock_out_enable;
   logic [parity_pkg::CA_W-1:0] ca_bits;
   logic [parity_pkg::CA_W:0] ones_acc;
   logic word_odd;
   logic advance;

   // pin levels are asynchronous to the core clock
   level_sync #(
      .WIDTH(3)
   ) u_pin_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .async_in({ck_in, ck_n_in, analog_supply}),
      .sync_out(pin_sync)
   );

   assign ck_s = pin_sync[2];
   assign ck_n_s = pin_sync[1];
   assign analog_s = pin_sync[0];

   // enable tracks its mode word bit directly, high means the clock pairs float; the feedback clock keeps driving
   assign clock_out_enable = drv_mode_word[parity_pkg::MODE_CLK_OFF_BIT];

   // only address, bank and command strobes enter the word;
   // clock enables, termination and chip selects are left out
   assign word_in.row_col_addr = row_col_addr_in;
   assign word_in.bank_addr = bank_addr_in;
   assign word_in.row_strobe_n = row_strobe_in_n;
   assign word_in.col_strobe_n = col_strobe_in_n;
   assign word_in.write_strobe_n = write_strobe_in_n;

   // running XOR over the registered word, one gate per bit
   assign ca_bits = st_r.word;
   assign ones_acc[0] = 1'b0;
   generate
      for (genvar i = 0; i < parity_pkg::CA_W; i++)
      begin : g_ones
         assign ones_acc[i+1] = ones_acc[i] ^ ca_bits[i];
      end
   endgenerate

   // low bit of the count of ones is all that parity needs
   assign word_odd = ones_acc[parity_pkg::CA_W];

   // the checker only moves while the input clock toggles
   assign advance = (st_r.clk_mode == parity_pkg::CLK_RUN);

   // next state
   always_comb
   begin
      st_nxt = st_r;

      // static clock detection: any change of ck restarts the count
      st_nxt.ck_prev = ck_s;
      if (ck_s != st_r.ck_prev)
      begin
         st_nxt.static_cnt = '0;
         st_nxt.clk_mode = parity_pkg::CLK_RUN;
      end
      else if (st_r.static_cnt != parity_pkg::STATIC_CNT_MAX)
      begin
         st_nxt.static_cnt = st_r.static_cnt + 1'b1;
      end
      else
      begin
         case (st_r.clk_mode)
            parity_pkg::CLK_RUN,
            parity_pkg::CLK_STOP_LOW,
            parity_pkg::CLK_STOP_HOLD:
            begin
               // both low parks the part; other static levels freeze it
               if (!ck_s && !ck_n_s)
                  st_nxt.clk_mode = parity_pkg::CLK_STOP_LOW;
               else
                  st_nxt.clk_mode = parity_pkg::CLK_STOP_HOLD;
            end
            default:
               st_nxt.clk_mode = parity_pkg::CLK_STOP_LOW;
         endcase
      end

      if (st_r.clk_mode == parity_pkg::CLK_STOP_LOW)
      begin
         // parked: flush the pipe so no stale error fires on restart
         st_nxt.sel = 1'b0;
         st_nxt.fail_a = 1'b0;
         st_nxt.fail_b = 1'b0;
         st_nxt.hold_cnt = '0;
         st_nxt.err_n = parity_pkg::ERR_IDLE_N;
      end
      else if (advance)
      begin
         // stage 0: register the word and whether any chip select is low
         st_nxt.word = word_in;
         st_nxt.sel = ~&chip_select_in_n;
         // stage 1: parity bit arrives one cycle after its word
         st_nxt.fail_a = st_r.sel & (word_odd ^ parity_bit_in);
         // stage 2: fail_a delayed one more edge; stage 1 already gave deselected words a clean pass
         st_nxt.fail_b = st_r.fail_a;
         // stage 3: drive the pin, third edge after the word
         if (!st_r.err_n && (st_r.hold_cnt != parity_pkg::ERR_HOLD_CYC - 2'h1))
         begin
            st_nxt.err_n = 1'b0;
            st_nxt.hold_cnt = st_r.hold_cnt + 2'h1;
         end
         else
         begin
            st_nxt.err_n = ~st_r.fail_b;
            st_nxt.hold_cnt = '0;
         end
      end
      // a static complementary clock leaves the error pin as it was

      // clock outputs follow the input level, pll or bypass alike
      st_nxt.y.pos = ck_s;
      st_nxt.y.neg = ~ck_s;
      st_nxt.fb.pos = ck_s;
      st_nxt.fb.neg = ~ck_s;
      st_nxt.y.oe = (st_r.clk_mode != parity_pkg::CLK_STOP_LOW) & ~clock_out_enable;
      st_nxt.fb.oe = (st_r.clk_mode != parity_pkg::CLK_STOP_LOW);

      // grounded analog supply bypasses the pll; timing is not guaranteed then
      st_nxt.pll_bypass = ~analog_s;
      st_nxt.pll_on = analog_s & (st_r.clk_mode != parity_pkg::CLK_STOP_LOW);
   end

   // reset floats every clock output, stops the pll and idles the error pin
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r.clk_mode <= parity_pkg::CLK_RUN;
         st_r.static_cnt <= '0;
         st_r.ck_prev <= 1'b0;
         st_r.word <= '0;
         st_r.sel <= 1'b0;
         st_r.fail_a <= 1'b0;
         st_r.fail_b <= 1'b0;
         st_r.err_n <= parity_pkg::ERR_IDLE_N;
         st_r.hold_cnt <= '0;
         st_r.y <= '0;
         st_r.fb <= '0;
         st_r.pll_on <= 1'b0;
         st_r.pll_bypass <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // open-drain: only ever pulls low
   assign parity_error_out_n = 1'b0;
   assign parity_error_oe = ~st_r.err_n;

   // fan the single clock level out to all pairs
   assign clock_out_pair = {parity_pkg::CLK_PAIRS{st_r.y.pos}};
   assign clock_out_pair_n = {parity_pkg::CLK_PAIRS{st_r.y.neg}};
   assign clock_out_oe = st_r.y.oe;
   assign feedback_clock_out = st_r.fb.pos;
   assign feedback_clock_out_n = st_r.fb.neg;
   assign feedback_clock_oe = st_r.fb.oe;
   assign pll_on = st_r.pll_on;
   assign pll_bypass = st_r.pll_bypass;

   // clock enables and termination do not take part in parity
   logic unused_ctrl;
   assign unused_ctrl = ^{clk_enable_in, termination_ctrl_in};

endmodule : cmd_parity_check_clock_out

// ==== rtl/level_sync.sv ====
/*
 * two-flop synchroniser for slow levels arriving from pins.
 * assumes the inputs are quasi-static relative to core_clk.
 */
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : level_sync

// ==== rtl/parity_pkg.sv ====
/*
 * constants, types and state layout for the command/address parity checker
 * and clock-output control block.
 * assumes one core clock at 50 MHz and an active-low asynchronous reset.
 */
package parity_pkg;

   // word and pin widths
   localparam int ROW_COL_W = 16;
   localparam int BANK_W = 3;
   localparam int CS_W = 4;
   localparam int CLK_PAIRS = 4;
   localparam int MODE_W = 4;

   // mode control word bit that disables the four clock pairs
   localparam int MODE_CLK_OFF_BIT = 0;

   // error pulse timing in core clock cycles
   localparam int ERR_DELAY_CYC = 3;
   localparam logic [1:0] ERR_HOLD_CYC = 2'h2;

   // a clock input that stands still this long counts as static
   localparam int CORE_CLK_MHZ = 50;
   localparam int STATIC_TIME_NS = 1000;
   localparam int STATIC_CYC = (STATIC_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam int STATIC_CNT_W = 8;
   localparam logic [STATIC_CNT_W-1:0] STATIC_CNT_MAX = STATIC_CNT_W'(STATIC_CYC);

   // reset values
   localparam logic ERR_IDLE_N = 1'b1;

   // command/address word covered by parity
   typedef struct packed {
      logic [ROW_COL_W-1:0] row_col_addr;
      logic [BANK_W-1:0] bank_addr;
      logic row_strobe_n;
      logic col_strobe_n;
      logic write_strobe_n;
   } ca_word_t;

   localparam int CA_W = $bits(ca_word_t);

   // one driven differential output pair
   typedef struct packed {
      logic pos;
      logic neg;
      logic oe;
   } diff_out_t;

   // state of the input clock as seen by the core clock
   typedef enum logic [2:0] {
      CLK_RUN = 3'b001,
      CLK_STOP_LOW = 3'b010,
      CLK_STOP_HOLD = 3'b100
   } clk_mode_t;

   // all state of the checker
   typedef struct packed {
      clk_mode_t clk_mode;
      logic [STATIC_CNT_W-1:0] static_cnt;
      logic ck_prev;
      ca_word_t word;
      logic sel;
      logic fail_a;
      logic fail_b;
      logic err_n;
      logic [1:0] hold_cnt;
      diff_out_t y;
      diff_out_t fb;
      logic pll_on;
      logic pll_bypass;
   } chk_state_t;

endpackage : parity_pkg
